// ### emx_pkg.sv
// Constants, field positions and carriers for the extension control block.
// Assumes a 16-bit register set reached as aligned 32-bit AXI4-Lite words.
// How it works
// R01 - Extension control register resets to all zeros; added features start off.
// R02 - Shared mode: timer control bit 6 enables both timer compare outputs.
// R03 - Shared mode: compare control bit 9 enables all three full-compare units.
// R04 - Shared mode: per-output and per-trip enable bits are ignored.
// R05 - Shared mode: with the protect mask set, protect flag disables all compare outputs together.
// R06 - Shared mode: protect mask gates interrupt and direct protect path.
// R07 - Independent mode: timer bits 5,4 and compare bits 7:5 enable outputs.
// R08 - Independent mode: timer bits 12,11, compare bits 2:0 enable trips.
// R09 - Independent mode: any enabled low trip sets the protect flag.
// R10 - Independent mode: protect mask only enables the interrupt.
// R11 - Qualifier off: index input passes through unchanged.
// R12 - Qualifier on: index passes only while both phases high, else low.
// R13 - Index enable clear: index edges never clear timer 2.
// R14 - Index enable set: qualified rising index edge clears timer 2.
// R15 - Conversion output on: each event drives a 32-cycle low pulse.
// R16 - Conversion output off: external conversion pin floats.
// R17 - Internal converter trigger ignores the conversion output enable.
// R18 - Shared mode, mask set: protect input low floats outputs; compare control bit 8 shows it.
// R19 - Software uses 16-bit accesses only; upper halfword is ignored.
// R20 - Extension control bits 15:4 read zero and ignore writes.
package emx_pkg;

  // Word byte offsets on the register bus
  localparam logic [7:0] OFS_EXT  = 8'h00;
  localparam logic [7:0] OFS_TCR  = 8'h04;
  localparam logic [7:0] OFS_CCR  = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Extension control fields
  localparam int unsigned EXT_INDEP = 0;
  localparam int unsigned EXT_QUAL  = 1;
  localparam int unsigned EXT_IDXEN = 2;
  localparam int unsigned EXT_SOCOE = 3;
  localparam int unsigned EXT_USED  = 4;

  // Timer and compare control fields
  localparam int unsigned TCR_SHARED  = 6;
  localparam int unsigned TCR_OEN_LO  = 4;
  localparam int unsigned TCR_TRIP_LO = 11;
  localparam int unsigned CCR_SHARED  = 9;
  localparam int unsigned CCR_OEN_LO  = 5;
  localparam int unsigned CCR_TRIP_LO = 0;
  localparam int unsigned CCR_PDP     = 8;
  localparam int unsigned FLAG_PROT   = 0;

  // Reset values
  localparam logic [15:0] EXT_RST  = 16'h0000;
  localparam logic [15:0] TCR_RST  = 16'h0000;
  localparam logic [15:0] CCR_RST  = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;

  // Conversion pulse: width in peripheral clocks, which is aclk here
  localparam int unsigned SOC_PULSE_HSP = 32;
  localparam logic [5:0]  SOC_PULSE_CYC = 6'(SOC_PULSE_HSP);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic idx;
    logic phase_b;
    logic phase_a;
  } emx_enc_s;

  // Active-low trip pins; bit 0 doubles as the protect input
  typedef struct packed {
    logic [2:0] c_trip_n;
    logic       t2_trip_n;
    logic       t1_pdp_n;
  } emx_trip_s;

endpackage : emx_pkg

// ### emx_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes inputs are levels from outside the aclk domain.
`timescale 1ns/1ns
`default_nettype none
module emx_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pin levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Reset to high: pins are idle-high active-low inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= '1;
      sync_ff <= '1;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;

endmodule : emx_sync
`default_nettype wire

// ### emx_soc_pulse.sv
// Retriggerable low-pulse timer for the external conversion start.
// Assumes start is a one-cycle pulse on aclk.
`timescale 1ns/1ns
`default_nettype none
module emx_soc_pulse (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic start,
  output logic      busy
);

  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;

  // A new event restarts the full width rather than merging
  assign nxt_cnt = start ? emx_pkg::SOC_PULSE_CYC
                 : (cnt_ff != 6'h00) ? cnt_ff - 6'h01 : 6'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= nxt_cnt;
  end

  assign busy = (cnt_ff != 6'h00);

endmodule : emx_soc_pulse
`default_nettype wire

// ### emx_top.sv
// Extension control: output and trip gating, index qualifier, conversion pin.
// Assumes an AXI4-Lite master on aclk and asynchronous encoder and trip pins.
`timescale 1ns/1ns
`default_nettype none
module emx_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Encoder pins
  input  wire logic        encoder_phase_a,
  input  wire logic        encoder_phase_b,
  input  wire logic        encoder_index_input,
  // Trip pins, active low
  input  wire logic        power_drive_protect_input_n,
  input  wire logic        t2_trip_n,
  input  wire logic [2:0]  c_trip_n,
  // Raw compare waveforms from the timers and compare units
  input  wire logic [1:0]  timer_cmp_raw,
  input  wire logic [5:0]  pwm_raw,
  // Compare pins
  output logic [1:0]       timer_cmp_out,
  output logic [1:0]       timer_cmp_oe_n,
  output logic [5:0]       pwm_out,
  output logic [5:0]       pwm_oe_n,
  output logic             protect_irq,
  // Index to capture and timer 2
  output logic             third_capture_input,
  output logic             timer2_clear,
  // Conversion start
  input  wire logic        conv_event,
  output logic             internal_conv_trigger,
  output logic             external_conv_start_pin_o,
  output logic             external_conv_start_pin_oe_n
);

  logic [15:0] ext_ff;
  logic [15:0] tcr_ff;
  logic [15:0] ccr_ff;
  logic [15:0] flag_ff;
  logic [15:0] mask_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic        qual_prev_ff;
  logic        idx_out_ff;
  logic        t2clr_ff;
  logic        int_trig_ff;
  logic        soc_pin_ff;
  logic        soc_oe_n_ff;
  logic [1:0]  tmr_out_ff;
  logic [1:0]  tmr_oe_n_ff;
  logic [5:0]  pwm_out_ff;
  logic [5:0]  pwm_oe_n_ff;

  // Pin synchronisation
  emx_pkg::emx_enc_s  enc_pins;
  emx_pkg::emx_enc_s  enc_s;
  emx_pkg::emx_trip_s trip_pins;
  emx_pkg::emx_trip_s trip_s;
  logic [7:0]         pins_sync;

  assign enc_pins  = '{idx: encoder_index_input,
                       phase_b: encoder_phase_b,
                       phase_a: encoder_phase_a};
  assign trip_pins = '{c_trip_n: c_trip_n,
                       t2_trip_n: t2_trip_n,
                       t1_pdp_n: power_drive_protect_input_n};

  emx_sync #(
    .W (8)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   ({enc_pins, trip_pins}),
    .pin_sync (pins_sync)
  );

  assign {enc_s, trip_s} = pins_sync;

  // Bus decode
  wire wr_go = awvalid & wvalid & ~bvalid_ff;
  wire rd_go = arvalid & ~rvalid_ff;
  wire [7:0] wa = {awaddr[7:2], 2'h0};
  wire [7:0] ra = {araddr[7:2], 2'h0};
  wire wa_ext  = (wa == emx_pkg::OFS_EXT);
  wire wa_tcr  = (wa == emx_pkg::OFS_TCR);
  wire wa_ccr  = (wa == emx_pkg::OFS_CCR);
  wire wa_flag = (wa == emx_pkg::OFS_FLAG);
  wire wa_mask = (wa == emx_pkg::OFS_MASK);
  wire wa_hit  = wa_ext | wa_tcr | wa_ccr | wa_flag | wa_mask;

  // Only the low halfword lanes reach the 16-bit registers
  wire [15:0] bmask = {{8{wstrb[1]}}, {8{wstrb[0]}}}; // R19
  wire [15:0] wd = wdata[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [15:0] m);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  wire [15:0] nxt_ext = merge(ext_ff, wd, bmask)
                        & 16'h000F; // R20

  // Mode and control
  wire indep  = ext_ff[emx_pkg::EXT_INDEP];
  wire qual   = ext_ff[emx_pkg::EXT_QUAL];
  wire idx_en = ext_ff[emx_pkg::EXT_IDXEN];
  wire soc_oe = ext_ff[emx_pkg::EXT_SOCOE];

  // Trip evaluation; a low pin is an active trip
  wire [4:0] trip_lo = ~trip_s;
  wire [4:0] trip_en = {ccr_ff[emx_pkg::CCR_TRIP_LO +: 3],
                        tcr_ff[emx_pkg::TCR_TRIP_LO +: 2]}; // R08
  wire [4:0] act_trip = trip_lo & trip_en;
  wire prot_mask = mask_ff[emx_pkg::FLAG_PROT];
  wire prot_flag = flag_ff[emx_pkg::FLAG_PROT];

  // Shared mode flags on the protect pin only
  wire flag_set = indep ? |act_trip // R09
                        : trip_lo[0];
  wire flag_clr = wr_go & wa_flag & wstrb[0]
                  & wdata[emx_pkg::FLAG_PROT];
  // Set wins so a trip in the clearing cycle is not lost
  wire nxt_flag = flag_set | (prot_flag & ~flag_clr);

  // Mask gates flag and raw pin together in shared mode only
  wire legacy_kill = prot_mask & (prot_flag | trip_lo[0]); // R05 R06 R18

  // Output enables
  logic [1:0] tmr_en;
  logic [5:0] pwm_en;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_tmr
      // Reserved bits of the other mode are not looked at
      assign tmr_en[gi] = indep
        ? tcr_ff[emx_pkg::TCR_OEN_LO + gi] & ~act_trip[gi] // R07 R04
        : tcr_ff[emx_pkg::TCR_SHARED] & ~legacy_kill; // R02
    end
    for (gi = 0; gi < 6; gi++)
    begin : g_pwm
      assign pwm_en[gi] = indep
        ? ccr_ff[emx_pkg::CCR_OEN_LO + gi / 2]
          & ~act_trip[2 + gi / 2] // R07 R04
        : ccr_ff[emx_pkg::CCR_SHARED] & ~legacy_kill; // R03
    end
  endgenerate

  // Index qualifier
  wire qual_out = qual ? (enc_s.idx & enc_s.phase_a & enc_s.phase_b) // R12
                       : enc_s.idx; // R11
  wire idx_rise = qual_out & ~qual_prev_ff;
  wire nxt_t2clr = idx_en & idx_rise; // R13 R14

  // Conversion start
  logic soc_busy;
  wire soc_start = conv_event & soc_oe; // R15

  emx_soc_pulse u_soc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (soc_start),
    .busy    (soc_busy)
  );

  // Read mux; bit 8 of compare control is the live protect pin
  wire [15:0] ccr_rd = {ccr_ff[15:9], trip_s[0], ccr_ff[7:0]}; // R18
  wire ra_hit = (ra == emx_pkg::OFS_EXT) | (ra == emx_pkg::OFS_TCR)
              | (ra == emx_pkg::OFS_CCR) | (ra == emx_pkg::OFS_FLAG)
              | (ra == emx_pkg::OFS_MASK);
  wire [15:0] rd_word =
      (ra == emx_pkg::OFS_EXT)  ? ext_ff  :
      (ra == emx_pkg::OFS_TCR)  ? tcr_ff  :
      (ra == emx_pkg::OFS_CCR)  ? ccr_rd  :
      (ra == emx_pkg::OFS_FLAG) ? flag_ff :
      (ra == emx_pkg::OFS_MASK) ? mask_ff : 16'h0000;

  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_ff  <= emx_pkg::EXT_RST; // R01
      tcr_ff  <= emx_pkg::TCR_RST;
      ccr_ff  <= emx_pkg::CCR_RST;
      flag_ff <= emx_pkg::FLAG_RST;
      mask_ff <= emx_pkg::MASK_RST;
    end
    else
    begin
      if (wr_go & wa_ext)
        ext_ff <= nxt_ext;
      if (wr_go & wa_tcr)
        tcr_ff <= merge(tcr_ff, wd, bmask);
      if (wr_go & wa_ccr)
        ccr_ff <= merge(ccr_ff, wd, bmask);
      if (wr_go & wa_mask)
        mask_ff <= merge(mask_ff, wd, bmask);
      flag_ff[emx_pkg::FLAG_PROT] <= nxt_flag;
    end
  end

  // Bus responses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= emx_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= emx_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wa_hit ? emx_pkg::RESP_OKAY : emx_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid_ff <= 1'b0;
      if (rd_go)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= ra_hit ? emx_pkg::RESP_OKAY : emx_pkg::RESP_SLVERR;
        rdata_ff  <= {16'h0000, rd_word};
      end
      else if (rready)
        rvalid_ff <= 1'b0;
    end
  end

  // Pin-side outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Sync stages reset high; start high so no false index edge
      qual_prev_ff <= 1'b1;
      idx_out_ff   <= 1'b0;
      t2clr_ff     <= 1'b0;
      int_trig_ff  <= 1'b0;
      soc_pin_ff   <= 1'b1;
      soc_oe_n_ff  <= 1'b1;
      tmr_out_ff   <= 2'h0;
      tmr_oe_n_ff  <= 2'h3;
      pwm_out_ff   <= 6'h00;
      pwm_oe_n_ff  <= 6'h3F;
    end
    else
    begin
      qual_prev_ff <= qual_out;
      idx_out_ff   <= qual_out;
      t2clr_ff     <= nxt_t2clr;
      int_trig_ff  <= conv_event; // R17
      soc_pin_ff   <= ~soc_busy;
      soc_oe_n_ff  <= ~soc_oe; // R16
      tmr_out_ff   <= timer_cmp_raw;
      tmr_oe_n_ff  <= ~tmr_en;
      pwm_out_ff   <= pwm_raw;
      pwm_oe_n_ff  <= ~pwm_en;
    end
  end

  assign awready = wr_go;
  assign wready  = wr_go;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = rd_go;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = rdata_ff;

  assign timer_cmp_out  = tmr_out_ff;
  assign timer_cmp_oe_n = tmr_oe_n_ff;
  assign pwm_out        = pwm_out_ff;
  assign pwm_oe_n       = pwm_oe_n_ff;
  // Mask is an interrupt enable in both modes
  assign protect_irq    = prot_flag & prot_mask; // R10

  assign third_capture_input          = idx_out_ff;
  assign timer2_clear                 = t2clr_ff;
  assign internal_conv_trigger        = int_trig_ff;
  assign external_conv_start_pin_o    = soc_pin_ff;
  assign external_conv_start_pin_oe_n = soc_oe_n_ff;

  // Checks
  logic [6:0] soc_run_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      soc_run_ff <= 7'h00;
    else if (soc_start)
      soc_run_ff <= 7'h00;
    else if (soc_busy)
      soc_run_ff <= soc_run_ff + 7'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_EXT_RESET: assert property (disable iff (1'b0) // R01
    $rose(aresetn) |-> (ext_ff == 16'h0000))
    else $error("extension control not zero after reset");
  AST_SHARED_TMR_OFF: assert property ( // R02
    (!indep && !tcr_ff[emx_pkg::TCR_SHARED]) |=> (timer_cmp_oe_n == 2'h3))
    else $error("timer outputs driven with shared enable clear");
  AST_SHARED_PWM_OFF: assert property ( // R03
    (!indep && !ccr_ff[emx_pkg::CCR_SHARED]) |=> (pwm_oe_n == 6'h3F))
    else $error("compare outputs driven with shared enable clear");
  AST_SHARED_KILL: assert property ( // R06
    (!indep && prot_mask && trip_lo[0]) |=> (&pwm_oe_n && &timer_cmp_oe_n))
    else $error("protect did not float outputs");
  AST_INDEP_FLAG: assert property ( // R09
    (indep && |act_trip) |=> prot_flag)
    else $error("enabled trip did not set protect flag");
  AST_QUAL_LOW: assert property ( // R12
    (qual && !(enc_s.phase_a && enc_s.phase_b)) |=> !third_capture_input)
    else $error("qualified index passed with a phase low");
  AST_IDX_OFF: assert property ( // R13
    !idx_en |=> !timer2_clear)
    else $error("timer 2 cleared with index disabled");
  AST_SOC_HIZ: assert property ( // R16
    !soc_oe |=> external_conv_start_pin_oe_n)
    else $error("conversion pin driven while disabled");
  AST_SOC_WIDTH: assert property ( // R15
    $fell(soc_busy) |->
      ($past(soc_run_ff) == 7'(emx_pkg::SOC_PULSE_HSP - 1)))
    else $error("conversion pulse width wrong");
  AST_INT_TRIG: assert property ( // R17
    conv_event |=> internal_conv_trigger)
    else $error("internal trigger missed");
  AST_EXT_RSVD: assert property ( // R20
    ext_ff[15:4] == 12'h000)
    else $error("reserved extension bits nonzero");

  COV_SOC_PULSE: cover property ($fell(soc_busy));
  COV_IDX_CLEAR: cover property (qual && timer2_clear);
  COV_INDEP_TRIP: cover property (indep && |act_trip ##1 protect_irq);

endmodule : emx_top
`default_nettype wire

// ### emx_far_model.sv
// Far-side model: quadrature encoder, trip switches and external converter.
// Assumes bench commands change just after aclk edges; pins are re-timed.
`timescale 1ns/1ns
`default_nettype none
module emx_far_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench commands: {idx, b, a} and {c_trip[2:0], t2, protect}
  input  wire logic [2:0] enc_cmd,
  input  wire logic [4:0] trip_cmd,
  // Conversion pin as the block drives it
  input  wire logic       soc_o,
  input  wire logic       soc_oe_n,
  // Pins toward the block
  output logic      [2:0] enc_ff,
  output logic      [4:0] trip_ff,
  // Length of the last low pulse seen by the converter
  output logic      [7:0] width_ff
);
  logic [7:0] cnt_ff;
  wire  logic soc_lvl;

  // Converter input has a pull-up, so a released pin reads high
  assign soc_lvl = soc_oe_n ? 1'b1 : soc_o;

  always @(posedge aclk)
  begin
    enc_ff  <= enc_cmd;
    trip_ff <= trip_cmd;
    if (!aresetn)
    begin
      cnt_ff   <= 8'h00;
      width_ff <= 8'h00;
    end
    else if (soc_lvl == 1'b0)
      cnt_ff <= cnt_ff + 8'h01;
    else if (cnt_ff != 8'h00)
    begin
      width_ff <= cnt_ff;
      cnt_ff   <= 8'h00;
    end
  end
endmodule : emx_far_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the extension control block.
// Assumes emx_pkg, emx_top and emx_far_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [7:0] RE = emx_pkg::OFS_EXT;
  localparam logic [7:0] RT = emx_pkg::OFS_TCR;
  localparam logic [7:0] RC = emx_pkg::OFS_CCR;
  localparam logic [7:0] RF = emx_pkg::OFS_FLAG;
  localparam logic [7:0] RM = emx_pkg::OFS_MASK;
  localparam logic [1:0] SE = emx_pkg::RESP_SLVERR;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, width;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, tc_raw, tc_out, tc_oe_n;
  logic [2:0]  enc_cmd, enc_pin;
  logic [4:0]  trip_cmd, trip_pin;
  logic [5:0]  pwm_raw, pwm_out, pwm_oe_n;
  logic        irq, tci, t2clr, conv_event, int_trig, soc_o, soc_oe_n;
  int          err_count, total_checks, cycles, clr_cnt, trig_cnt;

  emx_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .encoder_phase_a(enc_pin[0]), .encoder_phase_b(enc_pin[1]),
    .encoder_index_input(enc_pin[2]),
    .power_drive_protect_input_n(trip_pin[0]), .t2_trip_n(trip_pin[1]),
    .c_trip_n(trip_pin[4:2]), .timer_cmp_raw(tc_raw), .pwm_raw(pwm_raw),
    .timer_cmp_out(tc_out), .timer_cmp_oe_n(tc_oe_n), .pwm_out(pwm_out),
    .pwm_oe_n(pwm_oe_n), .protect_irq(irq), .third_capture_input(tci),
    .timer2_clear(t2clr), .conv_event(conv_event),
    .internal_conv_trigger(int_trig), .external_conv_start_pin_o(soc_o),
    .external_conv_start_pin_oe_n(soc_oe_n));

  emx_far_model u_far (.aclk(aclk), .aresetn(aresetn), .enc_cmd(enc_cmd),
    .trip_cmd(trip_cmd), .soc_o(soc_o), .soc_oe_n(soc_oe_n),
    .enc_ff(enc_pin), .trip_ff(trip_pin), .width_ff(width));

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Upper halfword is always written as zero: the registers are 16 bits
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er = 2'h0);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input logic [1:0] er = 2'h0);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, {16'h0000, exp});
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Two sync stages, output flop and model flop, plus margin
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask : settle

  task automatic oe(input logic [7:0] e);
    chk(32'({tc_oe_n, pwm_oe_n}), 32'(e));
  endtask : oe

  task automatic t_reset;
    chk(32'({tc_oe_n, pwm_oe_n, soc_oe_n}), 32'h1FF);
    rd(RE, 16'h0000);
    rd(RT, 16'h0000);
    rd(RC, 16'h0100);
    rd(RF, 16'h0000);
    rd(RM, 16'h0000);
    wr(RE, 16'hFFFF);
    rd(RE, 16'h000F);
    wr(8'h14, 16'h0001, SE);
    rd(8'h14, 16'h0000, SE);
    wr(RE, 16'h0000);
  endtask : t_reset

  task automatic t_shared;
    wr(RT, 16'h1830);
    wr(RC, 16'h00E7);
    settle;
    oe(8'hFF);
    wr(RT, 16'h0040);
    wr(RC, 16'h0200);
    settle;
    oe(8'h00);
    chk(32'({tc_out, pwm_out}), 32'({tc_raw, pwm_raw}));
    wr(RM, 16'h0001);
    trip_cmd <= 5'h1E;
    settle;
    oe(8'hFF);
    chk(irq, 1'b1);
    rd(RC, 16'h0200);
    trip_cmd <= 5'h1F;
    settle;
    oe(8'hFF);
    rd(RF, 16'h0001);
    rd(RC, 16'h0300);
    wr(RF, 16'h0001);
    settle;
    oe(8'h00);
    wr(RM, 16'h0000);
    trip_cmd <= 5'h1E;
    settle;
    oe(8'h00);
    chk(irq, 1'b0);
    trip_cmd <= 5'h1F;
    settle;
    wr(RF, 16'h0001);
  endtask : t_shared

  task automatic t_indep;
    wr(RE, 16'h0001);
    wr(RT, 16'h0850);
    wr(RC, 16'h02E1);
    settle;
    oe(8'h80);
    trip_cmd <= 5'h1B;
    settle;
    oe(8'h83);
    rd(RF, 16'h0001);
    chk(irq, 1'b0);
    wr(RM, 16'h0001);
    chk(irq, 1'b1);
    oe(8'h83);
    trip_cmd <= 5'h1D;
    settle;
    wr(RF, 16'h0001);
    oe(8'h80);
    rd(RF, 16'h0000);
    trip_cmd <= 5'h1E;
    settle;
    oe(8'hC0);
    rd(RF, 16'h0001);
    trip_cmd <= 5'h1F;
    settle;
    wr(RF, 16'h0001);
    wr(RM, 16'h0000);
    wr(RE, 16'h0000);
  endtask : t_indep

  task automatic t_index;
    clr_cnt = 0;
    enc_cmd <= 3'h4;
    settle;
    chk(tci, 1'b1);
    chk(clr_cnt, 0);
    enc_cmd <= 3'h0;
    wr(RE, 16'h0004);
    settle;
    enc_cmd <= 3'h4;
    settle;
    chk(clr_cnt, 1);
    enc_cmd <= 3'h0;
    wr(RE, 16'h0006);
    clr_cnt = 0;
    enc_cmd <= 3'h4;
    settle;
    chk(tci, 1'b0);
    chk(clr_cnt, 0);
    enc_cmd <= 3'h3;
    settle;
    enc_cmd <= 3'h7;
    settle;
    chk(tci, 1'b1);
    chk(clr_cnt, 1);
    enc_cmd <= 3'h0;
    wr(RE, 16'h0000);
  endtask : t_index

  task automatic t_conv;
    trig_cnt = 0;
    conv_event <= 1'b1;
    @(posedge aclk);
    conv_event <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(trig_cnt, 1);
    chk({width, soc_oe_n}, 9'h001);
    wr(RE, 16'h0008);
    trig_cnt = 0;
    conv_event <= 1'b1;
    @(posedge aclk);
    conv_event <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(width, emx_pkg::SOC_PULSE_HSP);
    chk(trig_cnt, 1);
  endtask : t_conv

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Pulse counters and the hang limit
  always @(posedge aclk)
  begin
    cycles++;
    if (t2clr === 1'b1) clr_cnt++;
    if (int_trig === 1'b1) trig_cnt++;
    if (cycles == 20000)
    begin
      err_count++;
      wrap_up;
    end
  end

  initial
  begin
    {err_count, total_checks, cycles, clr_cnt, trig_cnt} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, conv_event, enc_cmd} = '0;
    trip_cmd = 5'h1F;
    tc_raw   = 2'h1;
    pwm_raw  = 6'h2D;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_shared;
    t_indep;
    t_index;
    t_conv;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
